// file: core/usc_core.sv
// Serial core: fractional baud generator, transfer clock, framing and buffers
//
// Contract
// - Five clock modes: async normal, async double, sync master, sync slave, SPI master.
// - Internal fractional generator clocks async, sync master and SPI master modes.
// - Baud period setting accepted over 0 through 4095.
// - Signed scale exponent -7..+7 scales the async rate fractionally; sync and SPI master rates ignore it.
// - Normal async rate follows the 16-divisor equations, at most clock over 16.
// - Double speed uses divisor 8 instead of 16.
// - Sync and SPI rate is clock over twice period plus one.
// - Double speed receiver counts 8 ticks per bit instead of 16 and samples each bit once at mid-bit.
// - Transfer clock pin drives in master, is input in slave.
// - Sync receive samples on the edge opposite the transmit change edge.
// - One-wire mode routes transmit and receive through the receive pin.
// - SPI master disables async-only logic; buffers, shifters, generator stay.
// - Pin control and events identical between serial and SPI modes.
// - One write buffer ahead of the shifter gives gapless back-to-back frames.
// - Two-entry receive buffer; frame, overflow and parity errors flagged separately.
// - Optional even or odd parity generated on transmit, checked on receive.
// - Length counter may set data length; lookup outputs may code the line.
// - Inversion off: change on rising, sample on falling; inversion on swaps.
`timescale 1ns/1ps
`default_nettype none
module usc_core import usc_pkg::*; (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  // Configuration
  input  wire usc_mode_t              mode_i,
  input  wire logic                   double_speed_select_i,
  input  wire logic [USC_BAUD_PERIOD_SETTING_W-1:0]  baud_period_setting_i,
  input  wire logic [USC_SCALE_W-1:0] baud_scale_exponent_i,
  input  wire logic [3:0]             char_bits_i,
  input  wire logic                   parity_en_i,
  input  wire logic                   parity_odd_i,
  input  wire logic                   stop_two_i,
  input  wire logic                   msb_first_i,
  input  wire logic                   one_wire_i,
  input  wire logic                   pin_invert_setting_i,
  // Custom logic link
  input  wire logic                   var_len_en_i,
  input  wire logic [3:0]             peripheral_length_counter_i,
  input  wire logic                   lut_link_i,
  input  wire logic                   lut_tx_i,
  input  wire logic                   lut_rx_i,
  output logic                        tx_serial_o,
  // Transmit data
  input  wire logic                   tx_valid_i,
  input  wire logic [USC_DATA_W-1:0]  tx_data_i,
  output logic                        tx_ready_o,
  // Receive data and status
  output logic                        rx_valid_o,
  input  wire logic                   rx_ready_i,
  output logic [USC_DATA_W-1:0]       rx_data_o,
  output logic                        rx_frame_err_o,
  output logic                        rx_parity_err_o,
  output logic                        rx_overflow_o,
  // Pins
  output logic                        txd_o,
  input  wire logic                   rxd_i,
  output logic                        rxd_o,
  output logic                        rxd_oe_n_o,
  input  wire logic                   transfer_clock_pin_i,
  output logic                        transfer_clock_pin_o,
  output logic                        transfer_clock_pin_oe_n_o
);

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  logic is_async;
  logic is_spi;
  logic is_master;
  logic [3:0] os_last;
  logic [3:0] os_half;

  assign is_async  = (mode_i == USC_ASYNC);
  assign is_spi    = (mode_i == USC_SPI_MASTER);
  assign is_master = (mode_i == USC_SYNC_MASTER) || is_spi;
  assign os_last = double_speed_select_i ? 4'(USC_OS_DOUBLE - 5'h1) : 4'(USC_OS_NORMAL - 5'h1);
  assign os_half = double_speed_select_i ? 4'(USC_OS_DOUBLE >> 1) : 4'(USC_OS_NORMAL >> 1);

  // ********************************************************************
  // Fractional baud generator
  // ********************************************************************
  logic [USC_CNT_W-1:0]  cnt;
  logic [USC_CNT_W-1:0]  next_reload;
  logic [USC_FRAC_W-1:0] acc;
  logic [USC_FRAC_W:0]   sum;
  logic [18:0]           scaled;
  logic [2:0]            shamt;
  logic                  tick;

  always_comb begin
    // Negative exponent splits the period into whole and fractional cycles
    shamt  = 3'(~baud_scale_exponent_i[2:0] + 3'h1);
    scaled = {baud_period_setting_i, 7'h00} >> shamt;
    sum    = {1'b0, acc} + {1'b0, scaled[6:0]};
    if (!is_async) begin
      next_reload = USC_CNT_W'(baud_period_setting_i);
    end else if (!baud_scale_exponent_i[3]) begin
      next_reload = ((USC_CNT_W'(baud_period_setting_i) + 20'h00001)
                     << baud_scale_exponent_i[2:0]) - 20'h00001;
    end else begin
      next_reload = USC_CNT_W'(scaled[18:7]) + USC_CNT_W'(sum[USC_FRAC_W]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt  <= '0;
      acc  <= '0;
      tick <= 1'b0;
    end else if (cnt == '0) begin
      cnt  <= next_reload;
      tick <= 1'b1;
      if (is_async && baud_scale_exponent_i[3]) begin
        acc <= sum[USC_FRAC_W-1:0];
      end
    end else begin
      cnt  <= cnt - 20'h00001;
      tick <= 1'b0;
    end
  end

  // ********************************************************************
  // Transfer clock
  // ********************************************************************
  logic tx_act;
  logic xck_int;
  logic next_xck;
  logic xck_in_q;
  logic xck_in_qq;
  logic chg_ev;
  logic smp_ev;

  assign next_xck = (is_master && tx_act) ? (xck_int ^ tick) : USC_XCK_IDLE;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xck_int   <= USC_XCK_IDLE;
      xck_in_q  <= USC_XCK_IDLE;
      xck_in_qq <= USC_XCK_IDLE;
    end else begin
      xck_int   <= next_xck;
      xck_in_q  <= transfer_clock_pin_i ^ pin_invert_setting_i;
      xck_in_qq <= xck_in_q;
    end
  end

  // change on rising, sample on falling of the uninverted clock
  always_comb begin
    if (is_master) begin
      chg_ev = tx_act & tick & ~xck_int;
      smp_ev = tx_act & tick & xck_int;
    end else begin
      chg_ev = xck_in_q & ~xck_in_qq;
      smp_ev = ~xck_in_q & xck_in_qq;
    end
  end

  // ********************************************************************
  // Frame assembly
  // ********************************************************************
  logic [USC_DATA_W-1:0]  tx_buf;
  logic                   buf_valid;
  logic [3:0]             dlen;
  logic                   par_on;
  logic [USC_FRAME_W-1:0] next_frame;
  logic [3:0]             nbits;
  logic [USC_DATA_W-1:0]  dmask;

  always_comb begin
    if (var_len_en_i) begin
      dlen = peripheral_length_counter_i;
    end else begin
      dlen = is_spi ? USC_SPI_BITS : char_bits_i;
    end
    // no parity, start or stop in SPI; parity unsupported with variable length
    par_on     = parity_en_i & ~is_spi & ~var_len_en_i;
    dmask      = USC_DATA_W'((10'h001 << dlen) - 10'h001);
    next_frame = '1;
    if (is_spi) begin
      for (int i = 0; i < USC_DATA_W; i++) begin
        if (i < int'(dlen)) begin
          next_frame[i] = (msb_first_i && !var_len_en_i) ? tx_buf[4'(int'(dlen) - 1 - i)] : tx_buf[i];
        end
      end
      nbits = dlen;
    end else begin
      next_frame[0] = 1'b0;
      for (int i = 0; i < USC_DATA_W; i++) begin
        if (i < int'(dlen)) begin
          next_frame[i + 1] = tx_buf[i];
        end
      end
      if (par_on) begin
        next_frame[dlen + 4'h1] = ^(tx_buf & dmask) ^ parity_odd_i;
      end
      nbits = dlen + 4'h2 + 4'(par_on) + 4'(stop_two_i);
    end
  end

  // ********************************************************************
  // Transmitter
  // ********************************************************************
  logic [USC_FRAME_W-1:0] tx_sh;
  logic [3:0]             tx_nbits;
  logic [USC_IDX_W-1:0]   tx_idx;
  logic [3:0]             tx_os;
  logic                   tx_first;
  logic                   tx_last;
  logic                   end_tx;
  logic                   load;
  logic                   take;
  logic                   tx_bit;

  assign tx_last = (tx_idx == tx_nbits - 4'h1);
  assign end_tx  = tx_act & tx_last & (is_async ? (tick & (tx_os == os_last)) : smp_ev);
  // Async idle start waits for a tick: full start bit
  assign load    = buf_valid & ((~tx_act & (tick | ~is_async)) | end_tx);
  assign take    = tx_valid_i & tx_ready_o;
  assign tx_bit  = tx_act ? tx_sh[tx_idx] : USC_LINE_IDLE;

  // write buffer refills shifter at frame end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_valid  <= 1'b0;
      tx_buf     <= '0;
      tx_ready_o <= 1'b1;
    end else begin
      buf_valid  <= take | (buf_valid & ~load);
      tx_ready_o <= ~(take | (buf_valid & ~load));
      if (take) begin
        tx_buf <= tx_data_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_act   <= 1'b0;
      tx_sh    <= '1;
      tx_nbits <= 4'h1;
      tx_idx   <= '0;
      tx_os    <= '0;
      tx_first <= 1'b0;
    end else if (load) begin
      tx_act   <= 1'b1;
      tx_sh    <= next_frame;
      tx_nbits <= nbits;
      tx_idx   <= '0;
      tx_os    <= '0;
      tx_first <= 1'b1;
    end else if (end_tx) begin
      tx_act <= 1'b0;
    end else if (tx_act && is_async && tick) begin
      tx_os <= (tx_os == os_last) ? 4'h0 : tx_os + 4'h1;
      if (tx_os == os_last) begin
        tx_idx <= tx_idx + 4'h1;
      end
    end else if (tx_act && !is_async && chg_ev) begin
      // First rising edge keeps the bit placed at load time
      tx_first <= 1'b0;
      if (!tx_first) begin
        tx_idx <= tx_idx + 4'h1;
      end
    end
  end

  // ********************************************************************
  // Receiver
  // ********************************************************************
  logic                   rx_line;
  logic                   rx_act;
  logic [USC_FRAME_W-1:0] rx_sh;
  logic [USC_IDX_W-1:0]   rx_idx;
  logic [3:0]             rx_os;
  logic                   rx_done;
  logic                   rx_armed;
  logic                   rx_last;
  logic [USC_DATA_W-1:0]  rx_dat;
  logic                   rx_ferr;
  logic                   rx_perr;
  logic                   fifo_in_ready;

  // receive source: pin or lookup output
  assign rx_line = lut_link_i ? lut_rx_i : rxd_i;
  assign rx_last = (rx_idx == nbits - 4'h1);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_act  <= 1'b0;
      rx_sh   <= '1;
      rx_idx  <= '0;
      rx_os   <= '0;
      rx_done <= 1'b0;
      rx_armed <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (is_async) begin
        if (tick && !rx_act) begin
          // start counts only after idle, held low to mid-bit
          if (rx_line || !rx_armed) begin
            rx_os    <= '0;
            rx_armed <= rx_line;
          end else if (rx_os == os_half - 4'h1) begin
            rx_act   <= 1'b1;
            rx_armed <= 1'b0;
            rx_sh[0] <= 1'b0;
            rx_idx   <= 4'h1;
            rx_os    <= '0;
          end else begin
            rx_os <= rx_os + 4'h1;
          end
        end else if (tick) begin
          rx_os <= (rx_os == os_last) ? 4'h0 : rx_os + 4'h1;
          if (rx_os == os_last) begin
            rx_sh[rx_idx] <= rx_line;
            rx_idx        <= rx_idx + 4'h1;
            rx_act        <= ~rx_last;
            rx_done       <= rx_last;
          end
        end
      end else if (smp_ev) begin
        // sample edge opposite change edge; SPI follows its own frame
        if (rx_act) begin
          rx_sh[rx_idx] <= rx_line;
          rx_idx        <= rx_idx + 4'h1;
          rx_act        <= ~rx_last;
          rx_done       <= rx_last;
        end else if (is_spi ? tx_act : !rx_line) begin
          rx_sh[0] <= rx_line;
          rx_idx   <= 4'h1;
          rx_act   <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    rx_dat  = '0;
    rx_ferr = 1'b0;
    rx_perr = 1'b0;
    for (int i = 0; i < USC_DATA_W; i++) begin
      if (i < int'(dlen)) begin
        if (is_spi) begin
          rx_dat[i] = (msb_first_i && !var_len_en_i) ? rx_sh[4'(int'(dlen) - 1 - i)] : rx_sh[i];
        end else begin
          rx_dat[i] = rx_sh[i + 1];
        end
      end
    end
    if (!is_spi) begin
      rx_ferr = ~rx_sh[dlen + 4'h1 + 4'(par_on)];
      rx_perr = par_on & (^rx_dat ^ parity_odd_i ^ rx_sh[dlen + 4'h1]);
    end
  end

  usc_fifo2 #(
    .W (USC_RXW)
  ) u_rx_buf (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (rx_done),
    .in_data_i   ({rx_perr, rx_ferr, rx_dat}),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  ({rx_parity_err_o, rx_frame_err_o, rx_data_o})
  );

  // overflow stays until read; a new loss wins over the clear
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_overflow_o <= 1'b0;
    end else if (rx_done && !fifo_in_ready) begin
      rx_overflow_o <= 1'b1;
    end else if (rx_valid_o && rx_ready_i) begin
      rx_overflow_o <= 1'b0;
    end
  end

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  // same data pin control in every mode; clock pin output enabled in master modes only
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_o                     <= USC_LINE_IDLE;
      rxd_o                     <= USC_LINE_IDLE;
      rxd_oe_n_o                <= USC_OE_OFF;
      tx_serial_o               <= USC_LINE_IDLE;
      transfer_clock_pin_o      <= USC_XCK_IDLE;
      transfer_clock_pin_oe_n_o <= USC_OE_OFF;
    end else begin
      tx_serial_o               <= tx_bit;
      txd_o                     <= one_wire_i ? USC_LINE_IDLE : (lut_link_i ? lut_tx_i : tx_bit);
      rxd_o                     <= lut_link_i ? lut_tx_i : tx_bit;
      rxd_oe_n_o                <= ~(one_wire_i & tx_act);
      transfer_clock_pin_o      <= next_xck ^ pin_invert_setting_i;
      transfer_clock_pin_oe_n_o <= ~is_master;
    end
  end

endmodule
`default_nettype wire

// file: core/usc_fifo2.sv
// Two-entry receive buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/1ps
`default_nettype none
module usc_fifo2 #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic [1:0]   count;
  logic [1:0]   next_count;
  logic [W-1:0] tail;
  logic         push;
  logic         pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count       <= 2'h0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
    end else begin
      count       <= next_count;
      out_valid_o <= (next_count != 2'h0);
      in_ready_o  <= (next_count != 2'h2);
    end
  end

  // Head is the visible word, tail the second one
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_data_o <= '0;
      tail       <= '0;
    end else begin
      if (pop) begin
        out_data_o <= (count == 2'h2) ? tail : in_data_i;
      end else if (push && count == 2'h0) begin
        out_data_o <= in_data_i;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
        tail <= in_data_i;
      end
    end
  end

endmodule
`default_nettype wire

// file: core/usc_pkg.sv
// Shared constants and types for the serial clock generation and framing core
package usc_pkg;

  // ********************************************************************
  // Operating modes
  // ********************************************************************
  typedef enum logic [1:0] {
    USC_ASYNC       = 2'b00,
    USC_SYNC_MASTER = 2'b01,
    USC_SYNC_SLAVE  = 2'b10,
    USC_SPI_MASTER  = 2'b11
  } usc_mode_t;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int USC_BAUD_PERIOD_SETTING_W  = 12;
  localparam int USC_SCALE_W = 4;
  localparam int USC_CNT_W   = 20;
  localparam int USC_FRAC_W  = 7;
  localparam int USC_DATA_W  = 9;
  localparam int USC_FRAME_W = 13;
  localparam int USC_IDX_W   = 4;
  localparam int USC_RXW     = USC_DATA_W + 2;

  // ********************************************************************
  // Timing and framing counts
  // ********************************************************************
  localparam int          USC_CLK_HZ    = 20_000_000;
  localparam logic [4:0]  USC_OS_NORMAL = 5'h10;
  localparam logic [4:0]  USC_OS_DOUBLE = 5'h08;
  localparam logic [3:0]  USC_SPI_BITS  = 4'h8;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic USC_LINE_IDLE = 1'b1;
  localparam logic USC_XCK_IDLE  = 1'b0;
  localparam logic USC_OE_OFF    = 1'b1;

endpackage

// file: dv/tb_usc_core.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module tb_usc_core;
  import usc_pkg::*;
  logic clk_sys_i, resetn_i, double_speed_select_i, parity_en_i, parity_odd_i, stop_two_i, msb_first_i;
  logic one_wire_i, pin_invert_setting_i, lut_link_i, tx_valid_i, rx_ready_i, loop_en, part_line;
  logic tx_serial_o, tx_ready_o, rx_valid_o, rx_frame_err_o, rx_parity_err_o, rx_overflow_o;
  logic txd_o, rxd_o, rxd_oe_n_o, xck_o, xck_oe_n;
  usc_mode_t              mode_i;
  logic [USC_BAUD_PERIOD_SETTING_W-1:0]  baud_period_setting_i;
  logic [USC_SCALE_W-1:0] baud_scale_exponent_i;
  logic [USC_DATA_W-1:0]  tx_data_i, rx_data_o;
  wire logic              rxd_w;
  int                     bad_count, comparisons;
  assign rxd_w = loop_en ? txd_o : part_line;
  usc_core usc_core_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mode_i(mode_i),
    .double_speed_select_i(double_speed_select_i), .baud_period_setting_i(baud_period_setting_i),
    .baud_scale_exponent_i(baud_scale_exponent_i), .char_bits_i(4'h8), .parity_en_i(parity_en_i),
    .parity_odd_i(parity_odd_i), .stop_two_i(stop_two_i), .msb_first_i(msb_first_i),
    .one_wire_i(one_wire_i), .pin_invert_setting_i(pin_invert_setting_i), .var_len_en_i(1'b0),
    .peripheral_length_counter_i(4'h8), .lut_link_i(lut_link_i), .lut_tx_i(tx_serial_o),
    .lut_rx_i(rxd_w), .tx_serial_o(tx_serial_o), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
    .rx_frame_err_o(rx_frame_err_o), .rx_parity_err_o(rx_parity_err_o), .rx_overflow_o(rx_overflow_o),
    .txd_o(txd_o), .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o),
    .transfer_clock_pin_i(1'b0), .transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe_n_o(xck_oe_n)
  );
  usc_partner usc_partner_i (.clk_sys_i(clk_sys_i), .line_i(txd_o), .line_o(part_line));
  // ****************
  // Helpers
  // ****************
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic push(logic [8:0] d);
    int k;
    @(negedge clk_sys_i);
    tx_valid_i = 1'b1;
    tx_data_i = d;
    for (k = 0; k < 4000 && tx_ready_o !== 1'b1; k++) @(negedge clk_sys_i);
    if (k == 4000) bad_count++;
    @(negedge clk_sys_i);
    tx_valid_i = 1'b0;
  endtask
  task automatic pop();
    @(negedge clk_sys_i);
    rx_ready_i = 1'b1;
    @(negedge clk_sys_i);
    rx_ready_i = 1'b0;
  endtask
  function automatic logic [11:0] frm(logic [7:0] d, logic pe, logic po);
    frm = pe ? {2'b11, ^d ^ po, d, 1'b0} : {3'b111, d, 1'b0};
  endfunction
  function automatic int bitc(int p, int e, logic ds);
    bitc = (ds ? 8 : 16) * (e < 0 ? 1 + (p >> -e) : (p + 1) << e);
  endfunction
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    bad_count++;
    test_done();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [11:0] got;
    logic [7:0]  d [3];
    int          p, e, bc, n, k, t [2];
    void'($urandom(32'hB8DA4132));
    {resetn_i, tx_valid_i, rx_ready_i, loop_en, one_wire_i, lut_link_i, msb_first_i} = '0;
    {double_speed_select_i, parity_en_i, parity_odd_i, stop_two_i, pin_invert_setting_i} = '0;
    {baud_period_setting_i, baud_scale_exponent_i, tx_data_i} = '0;
    mode_i = USC_ASYNC;
    repeat (12) @(negedge clk_sys_i);
    chk("reset pins", 12'h01B, {tx_ready_o, txd_o, rx_valid_o, xck_oe_n, rxd_oe_n_o});
    resetn_i = 1'b1;
    // Async transmit, back to back; first pass a negative exponent
    for (int i = 0; i < 5; i++) begin
      p = i == 0 ? 2 : $urandom % 4;
      e = i == 0 ? -1 : (p == 0 ? 0 : $urandom % 2);
      {double_speed_select_i, parity_en_i, parity_odd_i, stop_two_i, lut_link_i} = 5'($urandom);
      baud_period_setting_i = 12'(p);
      baud_scale_exponent_i = 4'(e);
      bc = bitc(p, e, double_speed_select_i);
      n = 10 + parity_en_i + stop_two_i;
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      fork
        begin
          push({1'b0, d[0]});
          push({1'b0, d[1]});
        end
        for (int j = 0; j < 2; j++) begin
          usc_partner_i.recv(n, bc, got, t[j]);
          chk("tx frame", frm(d[j], parity_en_i, parity_odd_i) & (12'hFFF >> (12 - n)), got);
        end
      join
      chk("frame spacing", 12'(n * bc), 12'(t[1] - t[0]));
      repeat (bc) @(negedge clk_sys_i);
    end
    // Receive: frame error, parity error, then a word lost to overflow
    {parity_en_i, parity_odd_i, stop_two_i, baud_scale_exponent_i} = 7'h40;
    baud_period_setting_i = 12'h001;
    bc = bitc(1, 0, double_speed_select_i);
    for (int j = 0; j < 3; j++) begin
      d[j] = 8'($urandom);
      usc_partner_i.send(frm(d[j], 1'b1, 1'b0) ^ (j == 0 ? 12'h400 : j == 1 ? 12'h200 : 12'h0), 11, bc);
      repeat (2 * bc) @(negedge clk_sys_i);
    end
    chk("rx first", {4'hD, d[0]}, {rx_valid_o, rx_frame_err_o, rx_parity_err_o, rx_overflow_o, rx_data_o[7:0]});
    pop();
    chk("rx second", {4'hA, d[1]}, {rx_valid_o, rx_frame_err_o, rx_parity_err_o, rx_overflow_o, rx_data_o[7:0]});
    pop();
    chk("rx empty", 12'h0, {11'h0, rx_valid_o});
    // Sync and SPI master in loopback, both clock polarities
    loop_en = 1'b1;
    for (int j = 0; j < 4; j++) begin
      mode_i = j[1] ? USC_SPI_MASTER : USC_SYNC_MASTER;
      pin_invert_setting_i = j[0];
      msb_first_i = 1'($urandom);
      p = 2 + $urandom % 2;
      baud_period_setting_i = 12'(p);
      d[0] = 8'($urandom);
      repeat (2) @(negedge clk_sys_i);
      fork
        push({1'b0, d[0]});
        begin
          for (k = 0; k < 4000 && xck_o === pin_invert_setting_i; k++) @(negedge clk_sys_i);
          for (n = 0; n < 4000 && xck_o !== pin_invert_setting_i; n++) @(negedge clk_sys_i);
          chk("clock phase", 12'(p + 1), 12'(n));
        end
      join
      for (k = 0; k < 4000 && rx_valid_o !== 1'b1; k++) @(negedge clk_sys_i);
      if (k == 4000) bad_count++;
      chk("loop word", {4'h0, d[0]}, {rx_frame_err_o, rx_parity_err_o, 2'b00, rx_data_o[7:0]});
      pop();
    end
    // Slave direction and one-wire pin levels
    // slave clock left still
    mode_i = USC_SYNC_SLAVE;
    one_wire_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk("slave pins", 12'h3, {10'h0, xck_oe_n, txd_o});
    push(9'h000);
    repeat (3) @(negedge clk_sys_i);
    chk("one-wire drive", 12'h0, {10'h0, rxd_oe_n_o, rxd_o});
    test_done();
  end
endmodule
bind usc_core usc_core_monitor usc_core_monitor_i (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mode_i(mode_i), .one_wire_i(one_wire_i),
  .pin_invert_setting_i(pin_invert_setting_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .rx_overflow_o(rx_overflow_o),
  .txd_o(txd_o), .rxd_oe_n_o(rxd_oe_n_o), .transfer_clock_pin_o(transfer_clock_pin_o),
  .transfer_clock_pin_oe_n_o(transfer_clock_pin_oe_n_o)
);
`default_nettype wire

// file: dv/usc_core_monitor.sv
// Port assertions for the serial core
`timescale 1ns/1ps
`default_nettype none
module usc_core_monitor import usc_pkg::*; (
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  resetn_i,
  // Watched ports
  input wire usc_mode_t             mode_i,
  input wire logic                  one_wire_i,
  input wire logic                  pin_invert_setting_i,
  input wire logic                  tx_valid_i,
  input wire logic                  tx_ready_o,
  input wire logic                  rx_valid_o,
  input wire logic                  rx_ready_i,
  input wire logic [USC_DATA_W-1:0] rx_data_o,
  input wire logic                  rx_overflow_o,
  input wire logic                  txd_o,
  input wire logic                  rxd_oe_n_o,
  input wire logic                  transfer_clock_pin_o,
  input wire logic                  transfer_clock_pin_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ****************
  // Pins
  // ****************
  a_clk_pin_out:
    assert property (mode_i inside {USC_SYNC_MASTER, USC_SPI_MASTER} |=> !transfer_clock_pin_oe_n_o)
    else $error("clock pin not driven");
  a_clk_pin_in:
    assert property (mode_i inside {USC_ASYNC, USC_SYNC_SLAVE} |=> transfer_clock_pin_oe_n_o)
    else $error("clock pin driven");
  a_clk_idle_level:
    assert property (mode_i == USC_ASYNC |=> transfer_clock_pin_o == $past(pin_invert_setting_i))
    else $error("clock idle level");
  a_ow_txd_high:
    assert property (one_wire_i |=> txd_o)
    else $error("txd not high in one-wire");
  a_ow_release:
    assert property (!one_wire_i |=> rxd_oe_n_o)
    else $error("rxd driven outside one-wire");
  // ****************
  // Buffers
  // ****************
  a_tx_ready_drop:
    assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
    else $error("write buffer still ready");
  a_rx_head_hold:
    assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("head word lost");
  a_ovf_sticky:
    assert property (rx_overflow_o && !rx_ready_i |=> rx_overflow_o)
    else $error("overflow dropped");
endmodule
`default_nettype wire

// file: dv/usc_partner.sv
// Remote serial device: frame sender and line listener
`timescale 1ns/1ps
`default_nettype none
module usc_partner (
  // Clock and lines
  input  wire logic clk_sys_i,
  input  wire logic line_i,
  output logic      line_o
);
  int now;
  always @(posedge clk_sys_i) now <= now + 1;
  initial line_o = 1'b1;
  task automatic send(logic [11:0] b, int n, int bc);
    for (int i = 0; i < n; i++) begin
      line_o = b[i];
      repeat (bc) @(negedge clk_sys_i);
    end
    line_o = 1'b1;
  endtask
  // Centre sampling; returns at last stop centre so the next start is seen
  task automatic recv(int n, int bc, output logic [11:0] b, output int t0);
    int k;
    b = '0;
    for (k = 0; k < 4000 && line_i !== 1'b0; k++) @(negedge clk_sys_i);
    t0 = now;
    repeat (bc / 2) @(negedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      b[i] = line_i;
      if (i < n - 1) repeat (bc) @(negedge clk_sys_i);
    end
  endtask
endmodule
`default_nettype wire
